// ---- hdl/sre_top.sv ----
/*
 On-chip SRAM wrapper with per-word check codes, region decode, read-modify-write
 for narrow writes and per-bank error flags, fault address and interrupts.
 Assumes a simple same-clock request/ready bus master and one system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sre_top
	import sre_pkg::*;
#(
	parameter int MEM_WORDS = TOTAL_WORDS
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Bus request
	input wire logic bus_req,
	input wire logic bus_write,
	input wire logic [1:0] bus_size,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	// Bus answer
	output logic bus_ready,
	output logic bus_err,
	output logic [31:0] bus_rdata,
	// Configuration
	input wire logic option_ecc_enable,
	input wire logic [NUM_BANKS-1:0] bank_check_enable,
	input wire logic [NUM_BANKS-1:0] single_error_irq_enable,
	input wire logic [38:0] fault_inject_mask,
	// Flag clears, one bit per bank, pulse means write one
	input wire logic [NUM_BANKS-1:0] single_error_clear,
	input wire logic [NUM_BANKS-1:0] multi_error_clear,
	// Status
	output logic [NUM_BANKS-1:0] single_error_flag,
	output logic [NUM_BANKS-1:0] multi_error_flag,
	output logic [NUM_BANKS-1:0][31:0] fault_address_field,
	output logic [BANK_W-1:0] last_bank,
	output logic [5:0] last_syndrome,
	output logic ecc_irq,
	output logic ecc_nmi
);

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CHECK} sre_state_t;

	function automatic sre_map_t map_addr(input logic [31:0] a);
		sre_map_t m;
		logic [31:0] ofs;
		m = '0;
		for (int b = 0; b < NUM_BANKS; b++) begin
			ofs = a - BANK_BASE[b];
			if (a >= BANK_BASE[b] && ofs < BANK_SIZE[b]) begin
				m.hit = 1'b1;
				m.bank = b[BANK_W-1:0];
				m.word = WORD_IDX_W'(BANK_WBASE[b] + (ofs >> 2));
			end
		end
		return m;
	endfunction : map_addr

	function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] ofs);
		logic [3:0] m;
		m = LANES_ALL;
		unique case (size)
			SZ_BYTE: m = LANE_ONE << ofs;
			SZ_HALF: m = ofs[1] ? LANES_HIGH : LANES_LOW;
			default: m = LANES_ALL;
		endcase
		return m;
	endfunction : lane_mask

	function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] lanes);
		logic [31:0] r;
		r = old_w;
		for (int l = 0; l < 4; l++) begin
			if (lanes[l]) begin
				r[l*8 +: 8] = new_w[l*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	logic [38:0] mem [MEM_WORDS];

	sre_state_t state_q;
	sre_map_t map_in;
	logic [3:0] lanes_in;
	logic take;
	logic full_write;
	logic [31:0] addr_q;
	logic [31:0] wdata_q;
	logic [3:0] lanes_q;
	logic write_q;
	logic [BANK_W-1:0] bank_q;
	logic [WORD_IDX_W-1:0] word_q;
	logic [38:0] rd_q;
	logic [31:0] merged;
	logic mem_we;
	logic [WORD_IDX_W-1:0] mem_idx;
	logic report_en;
	logic [NUM_BANKS-1:0] set_single;
	logic [NUM_BANKS-1:0] set_multi;
	logic bus_ready_q;
	logic bus_err_q;
	logic [31:0] bus_rdata_q;
	logic [NUM_BANKS-1:0] single_flag_q;
	logic [NUM_BANKS-1:0] multi_flag_q;
	logic [NUM_BANKS-1:0][31:0] fault_addr_q;
	logic [BANK_W-1:0] last_bank_q;
	logic [5:0] last_syndrome_q;
	logic irq_q;
	logic nmi_q;

	sre_ecc_if ecc ();

	sre_ecc_codec u_codec (
		.ecc(ecc.codec)
	);

	assign map_in = map_addr(bus_addr);
	assign lanes_in = lane_mask(bus_size, bus_addr[1:0]);
	assign take = (state_q == ST_IDLE) && bus_req && !bus_ready_q;
	assign full_write = take && map_in.hit && bus_write && (lanes_in == LANES_ALL);
	assign merged = merge(ecc.dec_fixed, wdata_q, lanes_q);
	assign mem_we = full_write || ((state_q == ST_CHECK) && write_q);
	assign mem_idx = full_write ? map_in.word : word_q;
	assign ecc.enc_data = full_write ? bus_wdata : merged;
	assign ecc.dec_data = rd_q[31:0];
	assign ecc.dec_code = rd_q[38:32];
	assign report_en = option_ecc_enable && bank_check_enable[bank_q];

	// Sequencer
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (take && map_in.hit && !full_write) begin
						state_q <= ST_READ;
					end
				end
				ST_READ: state_q <= ST_CHECK;
				ST_CHECK: state_q <= ST_IDLE;
			endcase
		end
	end

	// Request capture
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			addr_q <= '0;
			wdata_q <= '0;
			lanes_q <= '0;
			write_q <= 1'b0;
			bank_q <= '0;
			word_q <= '0;
		end else if (take) begin
			addr_q <= bus_addr;
			wdata_q <= bus_wdata;
			lanes_q <= lanes_in;
			write_q <= bus_write;
			bank_q <= map_in.bank;
			word_q <= map_in.word;
		end
	end

	// Storage: data and code written together
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			mem[mem_idx] <= {ecc.enc_code, ecc.enc_data} ^ fault_inject_mask;
		end
	end

	// Whole stored word is fetched for reads of any width and for narrow writes
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rd_q <= '0;
		end else if (state_q == ST_READ) begin
			rd_q <= mem[word_q];
		end
	end

	// Bus answer
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus_ready_q <= 1'b0;
			bus_err_q <= 1'b0;
			bus_rdata_q <= '0;
		end else begin
			bus_ready_q <= (take && (!map_in.hit || full_write)) || (state_q == ST_CHECK);
			bus_err_q <= take && !map_in.hit;
			if ((state_q == ST_CHECK) && !write_q) begin
				bus_rdata_q <= ecc.dec_fixed;
			end
		end
	end

	// Per-bank error events
	genvar gb;
	generate
		for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
			assign set_single[gb] = (state_q == ST_CHECK) && report_en && (bank_q == gb) && ecc.dec_single;
			assign set_multi[gb] = (state_q == ST_CHECK) && report_en && (bank_q == gb) && ecc.dec_double;

			// Set wins over a clear in the same cycle
			always_ff @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					single_flag_q[gb] <= 1'b0;
					multi_flag_q[gb] <= 1'b0;
				end else begin
					single_flag_q[gb] <= (single_flag_q[gb] && !single_error_clear[gb]) || set_single[gb];
					multi_flag_q[gb] <= (multi_flag_q[gb] && !multi_error_clear[gb]) || set_multi[gb];
				end
			end

			always_ff @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					fault_addr_q[gb] <= '0;
				end else if (set_single[gb] || set_multi[gb]) begin
					fault_addr_q[gb] <= addr_q;
				end
			end
		end
	endgenerate

	// Decoder diagnostics
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			last_bank_q <= '0;
			last_syndrome_q <= '0;
		end else if ((state_q == ST_CHECK) && report_en && (ecc.dec_single || ecc.dec_double)) begin
			last_bank_q <= bank_q;
			last_syndrome_q <= ecc.dec_syndrome;
		end
	end

	// Interrupt requests
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
			nmi_q <= 1'b0;
		end else begin
			irq_q <= |(single_flag_q & single_error_irq_enable);
			nmi_q <= |(multi_flag_q & single_error_irq_enable);
		end
	end

	assign bus_ready = bus_ready_q;
	assign bus_err = bus_err_q;
	assign bus_rdata = bus_rdata_q;
	assign single_error_flag = single_flag_q;
	assign multi_error_flag = multi_flag_q;
	assign fault_address_field = fault_addr_q;
	assign last_bank = last_bank_q;
	assign last_syndrome = last_syndrome_q;
	assign ecc_irq = irq_q;
	assign ecc_nmi = nmi_q;

	a_read_latency: assert property (@(posedge ref_clk) disable iff (reset)
		take && map_in.hit && !bus_write |-> !bus_ready_q ##1 !bus_ready_q ##1 !bus_ready_q ##1
		bus_ready_q && !bus_err_q)
		else $error("read answer not three edges after request");

	a_rmw_latency: assert property (@(posedge ref_clk) disable iff (reset)
		take && map_in.hit && bus_write && lanes_in != LANES_ALL |=> state_q == ST_READ ##1
		state_q == ST_CHECK && write_q ##1 bus_ready_q)
		else $error("narrow write skipped its read phase");

	a_full_write: assert property (@(posedge ref_clk) disable iff (reset)
		full_write |-> mem_we && ecc.enc_data == bus_wdata ##1 bus_ready_q && state_q == ST_IDLE)
		else $error("word write not stored in one cycle");

	a_unmapped_err: assert property (@(posedge ref_clk) disable iff (reset)
		take && !map_in.hit |=> bus_ready_q && bus_err_q && state_q == ST_IDLE)
		else $error("unmapped access not answered with error");

	a_single_flag: assert property (@(posedge ref_clk) disable iff (reset)
		state_q == ST_CHECK && report_en && ecc.dec_single |=> single_error_flag[$past(bank_q)] &&
		fault_address_field[$past(bank_q)] == $past(addr_q))
		else $error("single error not flagged with its address");

	a_multi_flag: assert property (@(posedge ref_clk) disable iff (reset)
		state_q == ST_CHECK && report_en && ecc.dec_double |=> multi_error_flag[$past(bank_q)] &&
		fault_address_field[$past(bank_q)] == $past(addr_q))
		else $error("double error not flagged with its address");

	a_gated_report: assert property (@(posedge ref_clk) disable iff (reset)
		!option_ecc_enable |=> (single_flag_q & ~$past(single_flag_q)) == '0 &&
		(multi_flag_q & ~$past(multi_flag_q)) == '0)
		else $error("flag rose while checking disabled");

	a_clear_flag: assert property (@(posedge ref_clk) disable iff (reset)
		(multi_error_clear & ~set_multi) != '0 |=>
		(multi_error_flag & $past(multi_error_clear & ~set_multi)) == '0)
		else $error("multi flag survived a clear");

	a_irq_raise: assert property (@(posedge ref_clk) disable iff (reset)
		(single_flag_q & single_error_irq_enable) != '0 |=> ecc_irq)
		else $error("interrupt missing for enabled single flag");

	a_nmi_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(ecc_nmi) |-> $past((multi_flag_q & single_error_irq_enable) != '0))
		else $error("nmi without enabled multi flag");

	a_single_clear: assert property (@(posedge ref_clk) disable iff (reset)
		(single_error_clear & ~set_single) != '0 |=>
		(single_error_flag & $past(single_error_clear & ~set_single)) == '0)
		else $error("single flag survived a clear");

	a_set_wins: assert property (@(posedge ref_clk) disable iff (reset)
		set_multi != '0 |=> (multi_flag_q & $past(set_multi)) == $past(set_multi))
		else $error("multi flag lost its setting event");

	a_irq_fall: assert property (@(posedge ref_clk) disable iff (reset)
		(single_flag_q & single_error_irq_enable) == '0 |=> !ecc_irq)
		else $error("interrupt without enabled single flag");

	a_fixed_data: assert property (@(posedge ref_clk) disable iff (reset)
		state_q == ST_CHECK && !write_q |=> bus_rdata == $past(ecc.dec_fixed))
		else $error("read answer is not the corrected word");

	a_unmapped_store: assert property (@(posedge ref_clk) disable iff (reset)
		take && !map_in.hit |-> !mem_we)
		else $error("unmapped access changed storage");

endmodule : sre_top
`default_nettype wire

// ---- hdl/sre_pkg.sv ----
/*
 Shared constants for the SRAM error-checking wrapper: bank map, access sizes,
 check-code layout and the code position table.
 Assumes a 32-bit byte address and 32-bit data words.
*/
package sre_pkg;

	localparam int NUM_BANKS = 5;
	localparam int BANK_W = 3;
	localparam int WORD_IDX_W = 19;
	localparam int DATA_W = 32;
	localparam int HAM_W = 6;
	localparam int CODE_W = 7;
	localparam int CODE_POSITIONS = 39;

	// Bank indices
	localparam logic [BANK_W-1:0] BANK_MAIN_A = 3'h0;
	localparam logic [BANK_W-1:0] BANK_MAIN_B = 3'h1;
	localparam logic [BANK_W-1:0] BANK_MAIN_C = 3'h2;
	localparam logic [BANK_W-1:0] BANK_ADDITIONAL = 3'h3;
	localparam logic [BANK_W-1:0] BANK_TIGHTLY = 3'h4;

	// Region bases and byte sizes, in bank index order
	localparam logic [31:0] BANK_BASE [NUM_BANKS] = '{32'h2000_0000, 32'h2004_0000, 32'h2005_0000,
		32'h2008_0000, 32'h1000_0000};
	localparam logic [31:0] BANK_SIZE [NUM_BANKS] = '{32'h0004_0000, 32'h0001_0000, 32'h0003_0000,
		32'h0008_0000, 32'h0001_0000};
	// Word offset of each bank inside the flat storage array
	localparam logic [31:0] BANK_WBASE [NUM_BANKS] = '{32'h0000_0000, 32'h0001_0000, 32'h0001_4000,
		32'h0002_0000, 32'h0004_0000};
	localparam int TOTAL_WORDS = 32'h0004_4000;

	// Access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [3:0] LANES_ALL = 4'hF;
	localparam logic [3:0] LANES_LOW = 4'h3;
	localparam logic [3:0] LANES_HIGH = 4'hC;
	localparam logic [3:0] LANE_ONE = 4'h1;

	typedef struct packed {
		logic hit;
		logic [BANK_W-1:0] bank;
		logic [WORD_IDX_W-1:0] word;
	} sre_map_t;

	// Code position of data bit idx: positions that are not powers of two
	function automatic logic [HAM_W-1:0] ecc_pos(input int idx);
		int n;
		logic [HAM_W-1:0] r;
		n = 0;
		r = '0;
		for (int p = 1; p < CODE_POSITIONS; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (n == idx) begin
					r = p[HAM_W-1:0];
				end
				n++;
			end
		end
		return r;
	endfunction : ecc_pos

endpackage : sre_pkg

// ---- hdl/sre_ecc_if.sv ----
/*
 Carrier between the wrapper and its check-code encoder/decoder.
 Assumes a purely combinational codec on the far side.
*/
`timescale 1ns/100ps
`default_nettype none
interface sre_ecc_if;
	logic [31:0] enc_data;
	logic [6:0] enc_code;
	logic [31:0] dec_data;
	logic [6:0] dec_code;
	logic [31:0] dec_fixed;
	logic [5:0] dec_syndrome;
	logic dec_single;
	logic dec_double;

	modport codec (input enc_data, dec_data, dec_code, output enc_code, dec_fixed, dec_syndrome, dec_single,
		dec_double);
	modport user (output enc_data, dec_data, dec_code, input enc_code, dec_fixed, dec_syndrome, dec_single,
		dec_double);
endinterface : sre_ecc_if
`default_nettype wire

// ---- hdl/sre_ecc_codec.sv ----
/*
 Single-error-correct, double-error-detect codec: 6 Hamming bits plus one
 overall parity bit per 32-bit word. Purely combinational.
 Assumes the caller registers the stored word before decoding.
*/
`timescale 1ns/100ps
`default_nettype none
module sre_ecc_codec
	import sre_pkg::*;
(
	// Codec port
	sre_ecc_if.codec ecc
);

	function automatic logic [HAM_W-1:0] hamming(input logic [DATA_W-1:0] d);
		logic [HAM_W-1:0] c;
		logic [HAM_W-1:0] p;
		c = '0;
		for (int i = 0; i < DATA_W; i++) begin
			p = ecc_pos(i);
			for (int k = 0; k < HAM_W; k++) begin
				if (p[k]) begin
					c[k] = c[k] ^ d[i];
				end
			end
		end
		return c;
	endfunction : hamming

	logic [HAM_W-1:0] enc_ham;
	logic [HAM_W-1:0] syn;
	logic par_err;

	always_comb begin
		enc_ham = hamming(ecc.enc_data);
		ecc.enc_code = {^{ecc.enc_data, enc_ham}, enc_ham};
	end

	always_comb begin
		syn = hamming(ecc.dec_data) ^ ecc.dec_code[HAM_W-1:0];
		par_err = ^{ecc.dec_data, ecc.dec_code};
		ecc.dec_fixed = ecc.dec_data;
		for (int i = 0; i < DATA_W; i++) begin
			if (par_err && (ecc_pos(i) == syn)) begin
				ecc.dec_fixed[i] = ~ecc.dec_data[i];
			end
		end
		ecc.dec_syndrome = syn;
		ecc.dec_single = par_err;
		ecc.dec_double = !par_err && (syn != '0);
	end

endmodule : sre_ecc_codec
`default_nettype wire

// ---- tb/sre_bus_model.sv ----
/*
 Bus master model: word, half and byte transfers on the request/ready bus.
 Assumes a same-clock slave that pulses ready once for each taken request.
*/
`timescale 1ns/100ps
`default_nettype none
module sre_bus_model
	import sre_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Request
	output var logic bus_req,
	output var logic bus_write,
	output var logic [1:0] bus_size,
	output var logic [31:0] bus_addr,
	output var logic [31:0] bus_wdata,
	// Answer
	input wire logic bus_ready,
	input wire logic bus_err,
	input wire logic [31:0] bus_rdata
);
	initial begin
		bus_req = 1'b0;
		bus_write = 1'b0;
		bus_size = SZ_WORD;
		bus_addr = 32'h0;
		bus_wdata = 32'h0;
	end

	// Holds the request until ready is sampled, then drops it and scrambles the address and write data lines
	// Ok stays low when the wait for ready runs out
	task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic ok);
		int n;
		n = 0;
		@(posedge ref_clk);
		bus_req <= 1'b1;
		bus_write <= wr;
		bus_size <= sz;
		bus_addr <= a;
		bus_wdata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (bus_ready !== 1'b1 && n < 16);
		rd = bus_rdata;
		err = bus_err;
		ok = (bus_ready === 1'b1);
		bus_req <= 1'b0;
		bus_addr <= ~a;
		bus_wdata <= ~d;
	endtask : xfer
endmodule : sre_bus_model
`default_nettype wire

// ---- tb/tb_sram_ecc_error_reporting.sv ----
/*
 Self-checking bench for the SRAM error-checking wrapper.
 Assumes the bus model makes every bus request; configuration is driven here.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_sram_ecc_error_reporting
	import sre_pkg::*;
;
	logic ref_clk, reset, bus_req, bus_write, bus_ready, bus_err;
	logic [1:0] bus_size;
	logic [31:0] bus_addr, bus_wdata, bus_rdata, rdat;
	logic option_ecc_enable, ecc_irq, ecc_nmi, rerr, rok;
	logic [4:0] bank_check_enable, single_error_irq_enable, single_error_clear, multi_error_clear;
	logic [4:0] single_error_flag, multi_error_flag;
	logic [38:0] fault_inject_mask;
	logic [4:0][31:0] fault_address_field;
	logic [2:0] last_bank;
	logic [5:0] last_syndrome;
	int error_cnt = 0;
	int n_tests = 0;

	sre_top sre_top_inst (.ref_clk, .reset, .bus_req, .bus_write, .bus_size, .bus_addr, .bus_wdata,
		.bus_ready, .bus_err, .bus_rdata, .option_ecc_enable, .bank_check_enable, .single_error_irq_enable,
		.fault_inject_mask, .single_error_clear, .multi_error_clear, .single_error_flag, .multi_error_flag,
		.fault_address_field, .last_bank, .last_syndrome, .ecc_irq, .ecc_nmi);
	sre_bus_model sre_bus_model_inst (.ref_clk, .bus_req, .bus_write, .bus_size, .bus_addr, .bus_wdata,
		.bus_ready, .bus_err, .bus_rdata);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	task automatic acc(input logic wr, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
		sre_bus_model_inst.xfer(wr, sz, a, d, rdat, rerr, rok);
		check("bus answer", {31'h0, rok}, 32'h1);
	endtask : acc

	// Stores one word with a flip pattern, then reads back its upper half
	task automatic flip_read(input logic [38:0] m, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		fault_inject_mask <= m;
		acc(1'b1, SZ_WORD, a, d);
		fault_inject_mask <= 39'h0;
		acc(1'b0, SZ_HALF, a + 32'h2, 32'h0);
	endtask : flip_read

	task automatic clr(input logic [4:0] s, input logic [4:0] m);
		@(posedge ref_clk);
		single_error_clear <= s;
		multi_error_clear <= m;
		@(posedge ref_clk);
		single_error_clear <= 5'h0;
		multi_error_clear <= 5'h0;
		tick(2);
	endtask : clr

	// All banks written first so that aliasing shows up on read back
	task automatic t_map();
		logic [31:0] a [10];
		logic [31:0] bad [4];
		a = '{32'h2000_0000, 32'h2003_FFFC, 32'h2004_0000, 32'h2004_FFFC, 32'h2005_0000, 32'h2007_FFFC,
			32'h2008_0000, 32'h200F_FFFC, 32'h1000_0000, 32'h1000_FFFC};
		bad = '{32'h2010_0000, 32'h1001_0000, 32'h3FFF_FFFC, 32'h0FFF_FFFC};
		foreach (a[i]) begin
			acc(1'b1, SZ_WORD, a[i], ~a[i]);
			check("map write err", {31'h0, rerr}, 32'h0);
		end
		foreach (bad[i]) begin
			acc(1'b1, SZ_WORD, bad[i], 32'h0);
			check("reserved write err", {31'h0, rerr}, 32'h1);
			acc(1'b0, SZ_WORD, bad[i], 32'h0);
			check("reserved read err", {31'h0, rerr}, 32'h1);
		end
		foreach (a[i]) begin
			acc(1'b0, SZ_WORD, a[i], 32'h0);
			check("map read err", {31'h0, rerr}, 32'h0);
			check("map read data", rdat, ~a[i]);
		end
	endtask : t_map

	task automatic t_narrow();
		acc(1'b1, SZ_WORD, 32'h2000_0100, 32'h1122_3344);
		acc(1'b1, SZ_BYTE, 32'h2000_0101, 32'h0000_AB00);
		acc(1'b1, SZ_HALF, 32'h2000_0102, 32'hCDEF_0000);
		acc(1'b0, SZ_BYTE, 32'h2000_0103, 32'h0);
		check("merged word", rdat, 32'hCDEF_AB44);
		acc(1'b1, SZ_HALF, 32'h2000_0100, 32'h0000_1357);
		acc(1'b0, SZ_WORD, 32'h2000_0100, 32'h0);
		check("low half merge", rdat, 32'hCDEF_1357);
		check("merge flags", {27'h0, single_error_flag | multi_error_flag}, 32'h0);
	endtask : t_narrow

	task automatic t_single();
		flip_read(39'h1, 32'h2004_0010, 32'h0000_00F0);
		check("corrected data", rdat, 32'h0000_00F0);
		check("single flags", {27'h0, single_error_flag}, 32'h2);
		check("single address", fault_address_field[1], 32'h2004_0012);
		check("syndrome", {26'h0, last_syndrome}, 32'h3);
		check("error bank", {29'h0, last_bank}, {29'h0, BANK_MAIN_B});
		tick(2);
		check("irq raised", {31'h0, ecc_irq}, 32'h1);
		clr(5'h0, 5'h02);
		check("single kept", {27'h0, single_error_flag}, 32'h2);
		clr(5'h02, 5'h0);
		check("single cleared", {27'h0, single_error_flag}, 32'h0);
		check("irq cleared", {31'h0, ecc_irq}, 32'h0);
	endtask : t_single

	task automatic t_double();
		flip_read(39'h3, 32'h1000_0020, 32'h8000_0001);
		check("multi flags", {27'h0, multi_error_flag}, 32'h10);
		check("no single", {27'h0, single_error_flag}, 32'h0);
		check("multi address", fault_address_field[4], 32'h1000_0022);
		tick(2);
		check("nmi raised", {31'h0, ecc_nmi}, 32'h1);
		check("irq quiet", {31'h0, ecc_irq}, 32'h0);
		clr(5'h0, 5'h10);
		check("multi cleared", {27'h0, multi_error_flag}, 32'h0);
		check("nmi cleared", {31'h0, ecc_nmi}, 32'h0);
	endtask : t_double

	// Check-bit flips under each gating setting
	task automatic t_gate();
		@(posedge ref_clk);
		option_ecc_enable <= 1'b0;
		flip_read(39'h01_0000_0000, 32'h2005_0040, 32'h5555_AAAA);
		check("data option off", rdat, 32'h5555_AAAA);
		check("option off", {27'h0, single_error_flag}, 32'h0);
		@(posedge ref_clk);
		option_ecc_enable <= 1'b1;
		bank_check_enable <= 5'h1B;
		flip_read(39'h01_0000_0000, 32'h2005_0040, 32'h5555_AAAA);
		check("bank off", {27'h0, single_error_flag}, 32'h0);
		@(posedge ref_clk);
		bank_check_enable <= 5'h1F;
		single_error_irq_enable <= 5'h1B;
		flip_read(39'h01_0000_0000, 32'h2005_0040, 32'h5555_AAAA);
		check("flag irq off", {27'h0, single_error_flag}, 32'h4);
		check("address irq off", fault_address_field[2], 32'h2005_0042);
		tick(2);
		check("irq masked", {31'h0, ecc_irq}, 32'h0);
		clr(5'h04, 5'h0);
	endtask : t_gate

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		reset = 1'b1;
		option_ecc_enable = 1'b1;
		bank_check_enable = 5'h1F;
		single_error_irq_enable = 5'h1F;
		fault_inject_mask = 39'h0;
		single_error_clear = 5'h0;
		multi_error_clear = 5'h0;
		tick(6);
		reset <= 1'b0;
		check("reset flags", {22'h0, single_error_flag, multi_error_flag}, 32'h0);
		t_map();
		t_narrow();
		t_single();
		t_double();
		t_gate();
		conclude();
	end

	// About 45 transfers of at most six cycles each fit well inside this span
	initial begin
		tick(5000);
		error_cnt++;
		conclude();
	end
endmodule : tb_sram_ecc_error_reporting
`default_nettype wire
